// >>> hdl/sdram_init_consts.svh
// Offsets, field positions and timing figures for SDRAM power-up and mode zero.
// Assumes inclusion by both link ends and by the package user files.
`ifndef SDRAM_INIT_CONSTS_SVH
`define SDRAM_INIT_CONSTS_SVH
`define CLK_NS 10
`define RESET_HOLD_US 200
`define CKE_WAIT_US 500
`define CKE_SETUP_NS 10
`define CLK_STABLE_NS 10
`define CLK_STABLE_CK 5
`define RESET_EXIT_MIN_CK 5
`define CK_HALF_CYC 8
`define CMD_NOP 4'h7
`define CMD_MRS 4'h0
`define CMD_ZQCL 4'h6
`define CMD_RD 4'h5
`define CMD_WR 4'h4
`define BIT_BL_LO 0
`define BIT_RBT 3
`define BIT_TEST 7
`define BIT_DLL_RESTART 8
`define BIT_WR_LO 9
`define BIT_PPD 12
`define BIT_DLL_OFF 0
`define BIT_ZQ_LONG 10
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_MODE0 8'h08
`define REG_MODE1 8'h0c
`define REG_MODE2 8'h10
`define REG_MODE3 8'h14
`define REG_ACCESS 8'h18
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// >>> hdl/sdram_init_pkg.sv
// Types shared by the controller end and the device end.
// Assumes nothing beyond a SystemVerilog compiler.
package sdram_init_pkg;
	typedef enum logic [1:0] {
		BURST_FIXED8 = 2'b00,
		BURST_PER_CMD = 2'b01,
		BURST_CHOP4 = 2'b10,
		BURST_RSVD = 2'b11
	} burst_mode_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RESET = 3'b001,
		ST_CKE_WAIT = 3'b010,
		ST_EXIT_WAIT = 3'b011,
		ST_MRS = 3'b100,
		ST_CAL_WAIT = 3'b101,
		ST_READY = 3'b110
	} ctrl_state_t;
endpackage

// >>> hdl/sdram_link_if.sv
// Pins between the memory controller and the SDRAM mode logic.
// Assumes the controller drives every pin; the device only listens.
`timescale 1ns/1ps
`default_nettype none
interface sdram_link_if;
	logic reset_n;
	logic ck;
	logic cke;
	logic odt;
	logic [3:0] cmd_n;
	logic [2:0] ba;
	logic [14:0] addr;
	modport ctrl (output reset_n, ck, cke, odt, cmd_n, ba, addr);
	modport dram (input reset_n, ck, cke, odt, cmd_n, ba, addr);
endinterface
`default_nettype wire

// >>> hdl/sdram_mode_device.sv
// Device end: reset, termination gating and mode zero decode.
// Assumes link pins arrive from the controller's clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "sdram_init_consts.svh"
module sdram_mode_device #(
	parameter int INIT_CYC = (`CKE_WAIT_US * 1000) / `CLK_NS,
	parameter int DLL_LOCK_CK = 512
) (
	// System
	input wire logic aclk,
	input wire logic aresetn,
	// Link
	sdram_link_if.dram link,
	// Decoded mode state
	output sdram_init_pkg::burst_mode_t burst_mode,
	output logic read_order_interleaved,
	output logic [3:0] read_latency,
	output logic latency_valid,
	output logic test_mode,
	output logic [3:0] write_recovery,
	output logic fast_exit,
	output logic dll_restart,
	// Per access
	output logic access_strobe,
	output logic access_is_write,
	output logic burst_eight,
	// Status
	output logic init_done,
	output logic termination_on,
	output logic early_cke_error,
	output logic early_read_error
);
	import sdram_init_pkg::*;
	logic [25:0] pins_meta;
	logic [25:0] pins;
	logic ck_prev;
	logic rise;
	logic cke_seen;
	logic [14:0] mode_config_zero;
	logic [31:0] init_cnt;
	logic [31:0] lock_cnt;
	logic [3:0] cmd_n;
	logic is_mrs0;
	logic is_rd;
	logic is_wr;
	logic [3:0] lat_code;
	logic [3:0] next_latency;
	logic [3:0] next_recovery;

	// Two-stage synchroniser for every link pin
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pins_meta <= 26'h0;
			pins <= 26'h0;
			ck_prev <= 1'b0;
		end else begin
			pins_meta <= {link.reset_n, link.ck, link.cke, link.odt, link.cmd_n,
				link.ba, link.addr};
			pins <= pins_meta;
			ck_prev <= pins[24];
		end
	end

	// Link clock edge and command decode
	assign rise = pins[24] && !ck_prev;
	assign cmd_n = pins[21:18];
	assign is_mrs0 = rise && pins[23] && cmd_n == `CMD_MRS && pins[17:15] == 3'h0;
	assign is_rd = rise && pins[23] && cmd_n == `CMD_RD;
	assign is_wr = rise && pins[23] && cmd_n == `CMD_WR;
	assign lat_code = {mode_config_zero[6:4], mode_config_zero[2]};

	always_comb begin
		unique case (lat_code)
			4'h2: next_latency = 4'h5;
			4'h4: next_latency = 4'h6;
			4'h6: next_latency = 4'h7;
			4'h8: next_latency = 4'h8;
			4'ha: next_latency = 4'h9;
			4'hc: next_latency = 4'ha;
			4'he: next_latency = 4'hb;
			4'h1: next_latency = 4'hc;
			4'h3: next_latency = 4'hd;
			4'h5: next_latency = 4'he;
			default: next_latency = 4'h0;
		endcase
	end

	always_comb begin
		unique case (mode_config_zero[11:9])
			3'h1: next_recovery = 4'h5;
			3'h2: next_recovery = 4'h6;
			3'h3: next_recovery = 4'h7;
			3'h4: next_recovery = 4'h8;
			3'h5: next_recovery = 4'ha;
			3'h6: next_recovery = 4'hc;
			3'h7: next_recovery = 4'he;
			default: next_recovery = 4'h0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || !pins[25]) begin
			init_cnt <= 32'h0;
			init_done <= 1'b0;
		end else if (init_cnt == 32'(INIT_CYC)) begin
			init_done <= 1'b1;
		end else begin
			init_cnt <= init_cnt + 32'h1;
		end
	end

	// termination gated by reset and first CKE
	always_ff @(posedge aclk) begin
		if (!aresetn || !pins[25]) begin
			cke_seen <= 1'b0;
			termination_on <= 1'b0;
			early_cke_error <= 1'b0;
		end else begin
			if (rise && pins[23]) begin
				cke_seen <= 1'b1;
				early_cke_error <= early_cke_error | !init_done;
			end
			termination_on <= cke_seen && pins[22];
		end
	end

	// mode zero stays until next MRS to it
	always_ff @(posedge aclk) begin
		if (!aresetn || !pins[25]) begin
			mode_config_zero <= 15'h0;
			dll_restart <= 1'b0;
		end else begin
			dll_restart <= 1'b0;
			if (is_mrs0) begin
				mode_config_zero <= pins[14:0] & ~(15'h1 << `BIT_DLL_RESTART);
				dll_restart <= pins[`BIT_DLL_RESTART];
			end
		end
	end

	// lock time watch for early reads
	always_ff @(posedge aclk) begin
		if (!aresetn || !pins[25]) begin
			lock_cnt <= 32'h0;
			early_read_error <= 1'b0;
		end else begin
			if (dll_restart) begin
				lock_cnt <= 32'(DLL_LOCK_CK);
			end else if (rise && lock_cnt != 32'h0) begin
				lock_cnt <= lock_cnt - 32'h1;
			end
			if (is_rd && lock_cnt != 32'h0) begin
				early_read_error <= 1'b1;
			end
		end
	end

	// Registered decode of mode zero fields
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			burst_mode <= BURST_FIXED8;
			read_order_interleaved <= 1'b0;
			read_latency <= 4'h0;
			latency_valid <= 1'b0;
			test_mode <= 1'b0;
			write_recovery <= 4'h0;
			fast_exit <= 1'b0;
		end else begin
			burst_mode <= burst_mode_t'(mode_config_zero[1:0]);
			read_order_interleaved <= mode_config_zero[`BIT_RBT];
			read_latency <= next_latency;
			latency_valid <= next_latency != 4'h0;
			test_mode <= mode_config_zero[`BIT_TEST];
			write_recovery <= next_recovery;
			fast_exit <= mode_config_zero[`BIT_PPD];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			access_strobe <= 1'b0;
			access_is_write <= 1'b0;
			burst_eight <= 1'b0;
		end else begin
			access_strobe <= is_rd || is_wr;
			if (is_rd || is_wr) begin
				access_is_write <= is_wr;
				unique case (burst_mode)
					BURST_PER_CMD: burst_eight <= pins[12];
					BURST_FIXED8: burst_eight <= 1'b1;
					default: burst_eight <= 1'b0;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// >>> hdl/sdram_init_ctrl.sv
// Controller end: power-up sequence, mode loads and calibration start.
// Assumes an AXI4-Lite master and a device end on the link interface.
`timescale 1ns/1ps
`default_nettype none
`include "sdram_init_consts.svh"
module sdram_init_ctrl #(
	parameter int RESET_HOLD_CYC = (`RESET_HOLD_US * 1000 + `CLK_NS - 1) / `CLK_NS,
	parameter int CKE_WAIT_CYC = (`CKE_WAIT_US * 1000 + `CLK_NS - 1) / `CLK_NS,
	parameter int CK_HALF = `CK_HALF_CYC,
	parameter int SELFREFRESH_EXIT_CK = 5,
	parameter int DLL_LOCK_CK = 512,
	parameter int CAL_INIT_CK = 512,
	parameter int MRS_GAP_CK = 4,
	parameter logic [2:0] WR_MIN_CODE = 3'h1
) (
	// System
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Link
	sdram_link_if.ctrl link
);
	import sdram_init_pkg::*;
	localparam int EXIT_CK = SELFREFRESH_EXIT_CK > `RESET_EXIT_MIN_CK ?
		SELFREFRESH_EXIT_CK : `RESET_EXIT_MIN_CK;
	localparam int CAL_CK = DLL_LOCK_CK > CAL_INIT_CK ? DLL_LOCK_CK : CAL_INIT_CK;
	localparam int STABLE_CYC = (`CLK_STABLE_NS + `CLK_NS - 1) / `CLK_NS;
	localparam int STABLE_CK = `CLK_STABLE_CK > STABLE_CYC ? `CLK_STABLE_CK : STABLE_CYC;
	ctrl_state_t state;
	logic [31:0] cnt;
	logic [2:0] idx;
	logic [7:0] div;
	logic fall;
	logic aw_have;
	logic w_have;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_fire;
	logic start;
	logic odt_level;
	logic [14:0] mode0;
	logic [14:0] mode1;
	logic [14:0] mode2;
	logic [14:0] mode3;
	logic acc_pend;
	logic acc_write;
	logic acc_eight;
	logic [31:0] merged;
	logic [2:0] wr_code;
	logic [2:0] mrs_bank;
	logic [14:0] mrs_addr;

	// Byte-lane merge of the write data
	always_comb begin
		merged = 32'h0;
		for (int i = 0; i < 4; i++) begin
			merged[8*i +: 8] = w_strb[i] ? w_data[8*i +: 8] : 8'h0;
		end
	end

	assign wr_code = mode0[11:9] < WR_MIN_CODE ? WR_MIN_CODE : mode0[11:9];

	// load order two, three, one, zero
	always_comb begin
		unique case (idx)
			3'h0: begin
				mrs_bank = 3'h2;
				mrs_addr = {2'h0, mode2[12:0]};
			end
			3'h1: begin
				mrs_bank = 3'h3;
				mrs_addr = {2'h0, mode3[12:0]};
			end
			3'h2: begin
				mrs_bank = 3'h1;
				mrs_addr = {2'h0, mode1[12:1], 1'b0};
			end
			default: begin
				mrs_bank = 3'h0;
				mrs_addr = {2'h0, mode0[12], wr_code, 1'b1, 1'b0, mode0[6:0]};
			end
		endcase
	end

	// Link clock divider, always running
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div <= 8'h0;
			link.ck <= 1'b0;
		end else if (div == 8'(CK_HALF - 1)) begin
			div <= 8'h0;
			link.ck <= !link.ck;
		end else begin
			div <= div + 8'h1;
		end
	end
	assign fall = div == 8'(CK_HALF - 1) && link.ck;

	// AXI write address and data capture
	assign wr_fire = aw_have && w_have && !bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have <= 1'b0;
			w_have <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			aw_addr <= 8'h0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
		end else begin
			if (awready && awvalid) begin
				aw_have <= 1'b1;
				aw_addr <= awaddr;
			end else if (wr_fire) begin
				aw_have <= 1'b0;
			end
			if (wready && wvalid) begin
				w_have <= 1'b1;
				w_data <= wdata;
				w_strb <= wstrb;
			end else if (wr_fire) begin
				w_have <= 1'b0;
			end
			awready <= !(awready && awvalid) && !aw_have;
			wready <= !(wready && wvalid) && !w_have;
		end
	end

	// Register writes and write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= `RESP_OKAY;
			start <= 1'b0;
			odt_level <= 1'b0;
			mode0 <= 15'h0;
			mode1 <= 15'h0;
			mode2 <= 15'h0;
			mode3 <= 15'h0;
			acc_pend <= 1'b0;
			acc_write <= 1'b0;
			acc_eight <= 1'b0;
		end else begin
			start <= 1'b0;
			if (state == ST_READY && fall && acc_pend) begin
				acc_pend <= 1'b0;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
			if (wr_fire) begin
				bvalid <= 1'b1;
				bresp <= `RESP_OKAY;
				unique case (aw_addr)
					`REG_CTRL: begin
						start <= merged[0];
						odt_level <= merged[1];
					end
					`REG_STATUS: ;
					`REG_MODE0: mode0 <= merged[14:0];
					`REG_MODE1: mode1 <= merged[14:0];
					`REG_MODE2: mode2 <= merged[14:0];
					`REG_MODE3: mode3 <= merged[14:0];
					`REG_ACCESS: begin
						acc_pend <= state == ST_READY;
						acc_write <= merged[0];
						acc_eight <= merged[1];
					end
					default: bresp <= `RESP_SLVERR;
				endcase
			end
		end
	end

	// Register reads
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= `RESP_OKAY;
		end else begin
			arready <= !(arready && arvalid) && !rvalid;
			if (arready && arvalid) begin
				rvalid <= 1'b1;
				rresp <= `RESP_OKAY;
				unique case (araddr)
					`REG_CTRL: rdata <= {30'h0, odt_level, 1'b0};
					`REG_STATUS: rdata <= {24'h0, acc_pend, state, link.cke,
						link.reset_n, 1'b0, state == ST_READY};
					`REG_MODE0: rdata <= {17'h0, mode0};
					`REG_MODE1: rdata <= {17'h0, mode1};
					`REG_MODE2: rdata <= {17'h0, mode2};
					`REG_MODE3: rdata <= {17'h0, mode3};
					`REG_ACCESS: rdata <= {30'h0, acc_eight, acc_write};
					default: begin
						rdata <= 32'h0;
						rresp <= `RESP_SLVERR;
					end
				endcase
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	// Power-up sequence; commands change on link clock falls
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
			cnt <= 32'h0;
			idx <= 3'h0;
			link.reset_n <= 1'b0;
			link.cke <= 1'b0;
			link.odt <= 1'b0;
			link.cmd_n <= `CMD_NOP;
			link.ba <= 3'h0;
			link.addr <= 15'h0;
		end else begin
			if (fall) begin
				link.cmd_n <= `CMD_NOP;
			end
			unique case (state)
				ST_IDLE: begin
					if (start) begin
						link.odt <= odt_level && ({mode1[9], mode1[6], mode1[2]} == 3'h0);
						link.reset_n <= 1'b0;
						link.cke <= 1'b0;
						cnt <= 32'(RESET_HOLD_CYC - 1);
						state <= ST_RESET;
					end
				end
				ST_RESET: begin
					// reset hold, clock enable already low
					if (cnt == 32'h0) begin
						link.reset_n <= 1'b1;
						cnt <= 32'(CKE_WAIT_CYC - 1);
						state <= ST_CKE_WAIT;
					end else begin
						cnt <= cnt - 32'h1;
					end
				end
				ST_CKE_WAIT: begin
					if (cnt != 32'h0) begin
						cnt <= cnt - 32'h1;
					end else if (fall) begin
						// clock enable held high from here
						link.cke <= 1'b1;
						cnt <= 32'(EXIT_CK > STABLE_CK ? EXIT_CK : STABLE_CK);
						state <= ST_EXIT_WAIT;
					end
				end
				ST_EXIT_WAIT: begin
					if (fall) begin
						if (cnt != 32'h0) begin
							cnt <= cnt - 32'h1;
						end else begin
							idx <= 3'h0;
							state <= ST_MRS;
						end
					end
				end
				ST_MRS: begin
					if (fall) begin
						if (cnt != 32'h0) begin
							cnt <= cnt - 32'h1;
						end else if (idx != 3'h4) begin
							link.cmd_n <= `CMD_MRS;
							link.ba <= mrs_bank;
							link.addr <= mrs_addr;
							idx <= idx + 3'h1;
							cnt <= 32'(MRS_GAP_CK - 1);
						end else begin
							link.cmd_n <= `CMD_ZQCL;
							link.ba <= 3'h0;
							link.addr <= 15'h1 << `BIT_ZQ_LONG;
							cnt <= 32'(CAL_CK - 1);
							state <= ST_CAL_WAIT;
						end
					end
				end
				ST_CAL_WAIT: begin
					if (fall) begin
						if (cnt != 32'h0) begin
							cnt <= cnt - 32'h1;
						end else begin
							state <= ST_READY;
						end
					end
				end
				ST_READY: begin
					if (fall && acc_pend) begin
						link.cmd_n <= acc_write ? `CMD_WR : `CMD_RD;
						link.addr <= acc_eight ? 15'h1000 : 15'h0;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> bench/sdram_link_monitor.sv
// Wire checker for the power-up sequence seen on the link pins.
// Assumes every pin is driven by the controller end from aclk flops.
`timescale 1ns/1ps
`default_nettype none
`include "sdram_init_consts.svh"
module sdram_link_monitor #(
	parameter int RESET_HOLD_CYC = 20,
	parameter int CKE_WAIT_CYC = 50,
	parameter int CK_HALF = 8
) (
	// System
	input wire logic aclk,
	input wire logic aresetn,
	// Link pins
	input wire logic reset_n,
	input wire logic ck,
	input wire logic cke,
	input wire logic odt,
	input wire logic [3:0] cmd_n,
	input wire logic [2:0] ba,
	input wire logic [14:0] addr
);
	logic [15:0] low_cnt, high_cnt, cke_cnt;
	logic [2:0] ck_rises, mrs_cnt;
	logic ck_q;
	wire logic ck_rise = ck & ~ck_q;
	wire logic mrs_seen = ck_rise && cmd_n == `CMD_MRS;

	// Required load sequence: two, three, one, zero
	function automatic logic [2:0] load_order(input logic [2:0] idx);
		case (idx)
			3'h0: return 3'h2;
			3'h1: return 3'h3;
			3'h2: return 3'h1;
			default: return 3'h0;
		endcase
	endfunction

	// Durations of reset low, reset high and clock enable high
	always_ff @(posedge aclk) begin
		low_cnt <= (!aresetn || reset_n) ? 16'h0 : low_cnt + {15'h0, low_cnt != 16'hffff};
		high_cnt <= (!aresetn || !reset_n) ? 16'h0 : high_cnt + {15'h0, high_cnt != 16'hffff};
		cke_cnt <= (!aresetn || !cke) ? 16'h0 : cke_cnt + {15'h0, cke_cnt != 16'hffff};
	end

	// Link clock rises seen so far, saturating at seven
	always_ff @(posedge aclk) begin
		ck_q <= aresetn & ck;
		ck_rises <= !aresetn ? 3'h0 : ck_rises + {2'h0, ck_rise && ck_rises != 3'h7};
	end

	// Mode loads registered since device reset
	always_ff @(posedge aclk) begin
		mrs_cnt <= (!aresetn || !reset_n) ? 3'h0 : mrs_cnt + {2'h0, mrs_seen && mrs_cnt != 3'h4};
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_RESET_HOLD: assert property ($rose(reset_n) |-> int'(low_cnt) >= RESET_HOLD_CYC - 1)
		else $error("device reset released too early");
	// Previous clock enable only matters when reset was already low one cycle before
	AST_CKE_LOW_AT_RELEASE: assert property ((!reset_n || $rose(reset_n)) |->
		!cke && ($past(reset_n) || !$past(cke)))
		else $error("clock enable not low around reset release");
	AST_CKE_WAIT: assert property ($rose(cke) |-> int'(high_cnt) >= CKE_WAIT_CYC - 1)
		else $error("clock enable raised too soon after reset");
	AST_CLOCK_FIRST: assert property ($rose(cke) |-> ck_rises >= 3'h5)
		else $error("link clock not running before clock enable");
	AST_NOP_FIRST: assert property ($rose(cke) |-> cmd_n == `CMD_NOP && $past(cmd_n) == `CMD_NOP)
		else $error("no idle command before clock enable");
	AST_CKE_HELD: assert property ($fell(cke) |-> !reset_n)
		else $error("clock enable dropped during init");
	AST_ODT_STATIC: assert property (cke && $past(cke) |-> $stable(odt))
		else $error("termination input moved");
	AST_EXIT_WAIT: assert property (mrs_seen |-> int'(cke_cnt) >= 10 * CK_HALF)
		else $error("mode load before reset exit wait");
	AST_LOAD_ORDER: assert property (mrs_seen |-> mrs_cnt < 3'h4 && ba == load_order(mrs_cnt))
		else $error("mode loads out of order");
	AST_DLL_ENABLE: assert property (mrs_seen && ba == 3'h1 |-> !addr[`BIT_DLL_OFF])
		else $error("mode one load leaves dll off");
	AST_DLL_RESTART: assert property (mrs_seen && ba == 3'h0 |-> addr[8] && addr[14:13] == 2'h0)
		else $error("mode zero load without dll restart");
	AST_WR_LEGAL: assert property (mrs_seen && ba == 3'h0 |-> addr[11:9] != 3'h0)
		else $error("reserved write recovery loaded");
	AST_TEST_OFF: assert property (mrs_seen && ba == 3'h0 |-> !addr[`BIT_TEST])
		else $error("test select loaded high");
	AST_CAL_AFTER_LOADS: assert property (ck_rise && cmd_n == `CMD_ZQCL |-> mrs_cnt == 3'h4 && addr[10])
		else $error("calibration not after four loads");
endmodule
`default_nettype wire

// >>> bench/sdram_powerup_init_and_mode0_tb.sv
// Testbench: controller and device joined on one link, driven over AXI4-Lite.
// Assumes shortened counts and the designer's register map.
`timescale 1ns/1ps
`default_nettype none
`include "sdram_init_consts.svh"
`define CHK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin mismatches++; $display("CHECK FAILED %s exp %0h got %0h", what, exp, got); end end
module sdram_powerup_init_and_mode0_tb;
	import sdram_init_pkg::*;
	localparam int RH = 20;
	localparam int CW = 50;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, st;
	logic [3:0] wstrb, read_latency, write_recovery;
	logic [1:0] bresp, rresp, rs, acc;
	burst_mode_t burst_mode;
	logic read_order_interleaved, latency_valid, test_mode, fast_exit, dll_restart, access_strobe;
	logic access_is_write, burst_eight, init_done, termination_on, early_cke_error, early_read_error;
	logic [14:0] mr0;
	logic odt_req, term;
	int mismatches, num_checks, seed, dll_cnt, dll0, k;
	logic [3:0] cl_codes [12] = '{4'h2, 4'h4, 4'h6, 4'h8, 4'ha, 4'hc, 4'he, 4'h1, 4'h3, 4'h5, 4'h0, 4'hf};
	sdram_link_if link();
	sdram_init_ctrl #(.RESET_HOLD_CYC(RH), .CKE_WAIT_CYC(CW), .DLL_LOCK_CK(8), .CAL_INIT_CK(8),
		.MRS_GAP_CK(2)) u_sdram_init_ctrl (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .link(link.ctrl));
	sdram_mode_device #(.INIT_CYC(40), .DLL_LOCK_CK(8)) u_sdram_mode_device (.aclk(aclk),
		.aresetn(aresetn), .link(link.dram), .burst_mode(burst_mode),
		.read_order_interleaved(read_order_interleaved), .read_latency(read_latency),
		.latency_valid(latency_valid), .test_mode(test_mode), .write_recovery(write_recovery),
		.fast_exit(fast_exit), .dll_restart(dll_restart), .access_strobe(access_strobe),
		.access_is_write(access_is_write), .burst_eight(burst_eight), .init_done(init_done),
		.termination_on(termination_on), .early_cke_error(early_cke_error),
		.early_read_error(early_read_error));
	sdram_link_monitor #(.RESET_HOLD_CYC(RH), .CKE_WAIT_CYC(CW), .CK_HALF(`CK_HALF_CYC))
		u_sdram_link_monitor (.aclk(aclk), .aresetn(aresetn), .reset_n(link.reset_n),
		.ck(link.ck), .cke(link.cke), .odt(link.odt), .cmd_n(link.cmd_n), .ba(link.ba),
		.addr(link.addr));

	// Clock
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	// Restart pulses and termination while clock enable is low
	always @(posedge aclk) begin
		if (dll_restart === 1'b1) dll_cnt++;
		if (aresetn && !link.cke) `CHK("termination_on", 1'b0, termination_on)
	end

	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task automatic hang();
		mismatches++;
		$display("CHECK FAILED wait exp done got timeout");
		results();
	endtask

	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 200);
		if (n >= 200) hang();
		resp = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 200);
		if (n >= 200) hang();
		d = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask

	function automatic logic [3:0] wr_clocks(input logic [2:0] c);
		logic [3:0] tbl [8] = '{4'd5, 4'd5, 4'd6, 4'd7, 4'd8, 4'd10, 4'd12, 4'd14};
		return tbl[c];
	endfunction

	task automatic check_decode(input int it);
		`CHK("burst_mode", burst_mode_t'(mr0[1:0]), burst_mode)
		`CHK("read_order", mr0[3], read_order_interleaved)
		`CHK("read_latency", (it < 10) ? 4'(it + 5) : 4'h0, read_latency)
		`CHK("latency_valid", it < 10, latency_valid)
		`CHK("test_mode", 1'b0, test_mode)
		`CHK("write_recovery", wr_clocks(mr0[11:9]), write_recovery)
		`CHK("fast_exit", mr0[12], fast_exit)
	endtask

	// Main sequence: one full power-up per read latency code
	initial begin
		seed = 38399;
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		wstrb = 4'hf;
		for (int it = 0; it < 12; it++) begin
			@(posedge aclk);
			aresetn <= 1'b0;
			repeat (2) @(posedge aclk);
			aresetn <= 1'b1;
			axi_read(`REG_STATUS, st, rs);
			`CHK("status idle", 32'h0, st)
			mr0 = 15'($random(seed));
			mr0[14:13] = 2'h0;
			mr0[11:9] = (it == 0) ? 3'h0 : mr0[11:9];
			{mr0[6:4], mr0[2]} = cl_codes[it];
			mr0[1:0] = it[1:0];
			odt_req = 1'($random(seed));
			term = (it % 3 == 0);
			axi_write(`REG_MODE2, $random(seed), rs);
			axi_write(`REG_MODE1, {29'h0, term, 1'b0, 1'($random(seed))}, rs);
			axi_write(`REG_MODE0, {17'h0, mr0}, rs);
			`CHK("mode write resp", `RESP_OKAY, rs)
			axi_write(`REG_CTRL, {30'h0, odt_req, 1'b1}, rs);
			dll0 = dll_cnt;
			st = '0;
			for (k = 0; k < 400 && st[0] !== 1'b1; k++) axi_read(`REG_STATUS, st, rs);
			if (st[0] !== 1'b1) hang();
			`CHK("status ready", 32'h6d, st)
			for (k = 0; k < 300 && init_done !== 1'b1; k++) @(posedge aclk);
			`CHK("init_done", 1'b1, init_done)
			`CHK("early_cke", 1'b0, early_cke_error)
			`CHK("odt pin", odt_req & ~term, link.odt)
			`CHK("termination on", odt_req & ~term, termination_on)
			`CHK("restart pulses", 1, dll_cnt - dll0)
			check_decode(it);
			acc = 2'($random(seed));
			axi_write(`REG_ACCESS, {30'h0, acc}, rs);
			for (k = 0; k < 300 && access_strobe !== 1'b1; k++) @(posedge aclk);
			if (access_strobe !== 1'b1) hang();
			`CHK("access_is_write", acc[0], access_is_write)
			if (mr0[1:0] != 2'h3) `CHK("burst_eight", (mr0[1:0] == 2'h1) ? acc[1] : mr0[1:0] == 2'h0, burst_eight)
			`CHK("early_read", 1'b0, early_read_error)
			check_decode(it);
		end
		axi_read(8'h1c, st, rs);
		`CHK("unmapped read", {`RESP_SLVERR, 32'h0}, {rs, st})
		axi_write(8'h1c, 32'hffffffff, rs);
		`CHK("unmapped write", `RESP_SLVERR, rs)
		results();
	end
endmodule
`default_nettype wire
